/* design/bus_grant_map.svh */
/*
  Timing and width constants for the external bus grant arbiter.
  Assumes inclusion by bare name from design files only.
*/
`ifndef BUS_GRANT_MAP_SVH
`define BUS_GRANT_MAP_SVH

// Least delay from request to grant, in peripheral clock cycles
`define GRANT_MIN_CYCLES 3
// Width of the grant delay counter
`define GRANT_CNT_W 2
// Reset value of the grant delay counter
`define GRANT_CNT_RESET 2'h0

`endif

/* design/bus_grant_pkg.sv */
/*
  Types for the external bus grant arbiter.
  Assumes no other package.
*/
package bus_grant_pkg;

  // Arbiter state, one-hot
  typedef enum logic [3:0] {
    ST_OWNED   = 4'h1,  // Device owns the bus
    ST_WAIT    = 4'h2,  // Request seen, waiting on internal traffic
    ST_FLOAT   = 4'h4,  // Drivers released, grant next
    ST_GRANTED = 4'h8   // Bus handed to outside master
  } arb_state_type;

endpackage : bus_grant_pkg

/* design/external_bus_grant_arbiter.sv */
/*
  External bus grant arbiter: lets an outside master take the address
  and data bus after internal traffic and any access in progress.
  Assumes the core and memory interface sit on clk_i and hold their
  request/access signals steady until serviced.
*/
// Contract
// - Synchronise request, arbitrate against internal requests
// - External request lowest priority, grant when idle
// - Grant no sooner than three cycles
// - Float drivers first, then assert grant; reset does both on one edge
// - Stall external fetches or accesses while granted
// - No grant between paired external reads
// - Grant allowed between read and write
// - Exclusive mode keeps bus for core
// - Resume exactly where stalled after release
// - Arbitration works in reset and boot
// - In reset grant when request recognised
// - Boot grants only after current byte
// - Hung output when ready but bus away
// - On return drop grant, hung, then access
// - Grant waits cycle after access completes
// - Only current access must finish
// - Drop grant when request removal recognised
`timescale 1ns/1ps
`default_nettype none
`include "bus_grant_map.svh"

module external_bus_grant_arbiter
  import bus_grant_pkg::*;
#(
  parameter int GRANT_DELAY = `GRANT_MIN_CYCLES  // Least request-to-grant delay, cycles
)
(
  input wire logic clk_i,                 // Peripheral clock, 100 MHz
  input wire logic rst_i,                 // Synchronous reset, active high
  input wire logic ce_i,                  // Clock enable, freezes all state
  input wire logic ext_bus_request_n_i,   // Outside master request, async
  input wire logic core_req_i,            // Core internal bus request
  input wire logic periph_req_i,          // Peripheral/DMA internal request
  input wire logic access_busy_i,         // External access in progress
  input wire logic read_pair_i,           // Between two reads of one instruction
  input wire logic exclusive_i,           // Core takes interface exclusively
  input wire logic boot_active_i,         // Boot loader running
  input wire logic boot_byte_busy_i,      // Boot byte load incl. wait states
  input wire logic ext_fetch_i,           // Core wants external memory space
  output logic bus_grant_n_o,             // Grant to outside master, low
  output logic grant_hung_n_o,            // Hung grant, low
  output logic drivers_en_o,              // Bus output drivers enabled
  output logic core_stall_o               // Hold the core pipeline
);

  // All state in one struct
  typedef struct packed {
    logic req_meta;               // Synchroniser first stage
    logic req_sync;               // Synchroniser second stage, high = request
    logic [`GRANT_CNT_W-1:0] cnt; // Cycles since request seen
    arb_state_type st;            // Arbiter state
    logic grant;                  // Grant asserted
    logic hung;                   // Hung grant asserted
    logic drv_en;                 // Drivers enabled
  } arb_regs_type;

  arb_regs_type state_reg;
  arb_regs_type state_next;
  logic internal_busy;  // Any reason to keep the bus
  logic req_now;        // Synchronised request level

  // Refuse a delay the two-bit wait counter cannot count out;
  // below three the synchroniser alone would break the minimum
  if (GRANT_DELAY < 3 || GRANT_DELAY > (1 << `GRANT_CNT_W)) begin : g_delay_check
    $error("Grant delay not servable by the wait counter");
  end

  // Last wait cycle reached; shared by the count, the float step and a check
  function automatic logic wait_done(input logic [`GRANT_CNT_W-1:0] cnt);
    return cnt == `GRANT_CNT_W'(GRANT_DELAY - 1);
  endfunction : wait_done

  // Bus back with the device: grant and hung off, drivers on, count cleared.
  // Used by reset, release, withdrawal and illegal codes so they cannot drift.
  function automatic arb_regs_type owned_state(input arb_regs_type cur);
    arb_regs_type r;
    r = cur;
    r.st = ST_OWNED;
    r.cnt = `GRANT_CNT_RESET;
    r.grant = 1'b0;
    r.hung = 1'b0;
    r.drv_en = 1'b1;
    return r;
  endfunction : owned_state

  // Bus handed away: drivers floated and grant raised in one step.
  // Only reset takes this shortcut; normal grants float a cycle ahead.
  function automatic arb_regs_type granted_state(input arb_regs_type cur);
    arb_regs_type r;
    r = cur;
    r.st = ST_GRANTED;
    r.cnt = `GRANT_CNT_RESET;
    r.grant = 1'b1;
    r.hung = 1'b0;
    r.drv_en = 1'b0;
    return r;
  endfunction : granted_state

  // Blocking conditions, decided before each grant
  always_comb begin
    req_now = state_reg.req_sync;
    // Internal requests beat the outside master; in reset nothing blocks
    internal_busy = !rst_i && (core_req_i || periph_req_i || access_busy_i ||
                    read_pair_i || exclusive_i ||
                    (boot_active_i && boot_byte_busy_i));
  end

  // Next-state logic; the synchroniser runs in every state, reset included
  always_comb begin
    state_next = state_reg;
    state_next.req_meta = !ext_bus_request_n_i;
    state_next.req_sync = state_reg.req_meta;
    if (rst_i) begin
      // Reset keeps arbitration alive: the bus follows the synced request
      if (req_now) begin
        // Grant on the cycle the request is recognised, no float step
        state_next = granted_state(state_next);
      end else begin
        // No request: device owns the bus; an unknown power-up state lands here
        state_next = owned_state(state_next);
      end
    end else begin
      unique case (state_reg.st)
        ST_OWNED: begin
          state_next.cnt = `GRANT_CNT_RESET;
          if (req_now) begin
            state_next.st = ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Count the delay, saturating on the last wait cycle
          if (!wait_done(state_reg.cnt)) begin
            state_next.cnt = state_reg.cnt + `GRANT_CNT_W'(1);
          end
          if (!req_now) begin
            // Request withdrawn before grant
            state_next = owned_state(state_next);
          end else if (!internal_busy && wait_done(state_reg.cnt)) begin
            // Float drivers one cycle before grant; a write after a read may
            // lose the bus here since only the current access must end
            state_next.st = ST_FLOAT;
            state_next.drv_en = 1'b0;
          end else begin
            // Internal traffic or the delay still holds the request off
            state_next.st = ST_WAIT;
          end
        end
        ST_FLOAT: begin
          if (req_now) begin
            // Drivers already off since last edge, grant now
            state_next.grant = 1'b1;
            state_next.st = ST_GRANTED;
          end else begin
            // Master gave up meanwhile; take the bus back
            state_next = owned_state(state_next);
          end
        end
        ST_GRANTED: begin
          // Hung follows a core that waits on external space
          state_next.hung = ext_fetch_i;
          if (!req_now) begin
            // Release: grant and hung drop together, drivers back on the same edge
            state_next = owned_state(state_next);
          end
        end
        default: begin
          // Illegal code recovers to owned
          state_next = owned_state(state_next);
        end
      endcase
    end
  end

  // Register the state; the clock enable freezes everything, reset included
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Outputs from flip-flops; stall is a handshake so may be combinational
  assign bus_grant_n_o = !state_reg.grant;
  assign grant_hung_n_o = !state_reg.hung;
  assign drivers_en_o = state_reg.drv_en;
  // Stall only holds the core, so nothing is lost or repeated
  assign core_stall_o = ext_fetch_i && (state_reg.grant || !state_reg.drv_en);

  // Assertions
  property p_float_before_grant;
    @(posedge clk_i) disable iff (rst_i)
      $fell(bus_grant_n_o) |-> !drivers_en_o && !$past(drivers_en_o);
  endproperty
  a_float_before_grant: assert property (p_float_before_grant)
    else $error("Grant asserted without drivers floated");

  property p_min_delay;
    @(posedge clk_i) disable iff (rst_i)
      $fell(bus_grant_n_o) |-> $past(state_reg.req_sync, 3);
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("Grant sooner than three cycles");

  property p_no_grant_busy;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_reg.st == ST_WAIT && internal_busy) |=> state_reg.st != ST_FLOAT;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("Bus floated while internal traffic pending");

  property p_stall;
    @(posedge clk_i) (!bus_grant_n_o && ext_fetch_i) |-> core_stall_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Core not stalled while bus granted");

  property p_release;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_reg.st == ST_GRANTED && !state_reg.req_sync) |=> bus_grant_n_o && grant_hung_n_o;
  endproperty
  a_release: assert property (p_release)
    else $error("Grant not dropped on release");

  property p_hung;
    @(posedge clk_i) disable iff (rst_i)
      !grant_hung_n_o |-> !bus_grant_n_o;
  endproperty
  a_hung: assert property (p_hung)
    else $error("Hung grant without grant");

  property p_reset_grant;
    @(posedge clk_i)
      (rst_i && ce_i && state_reg.req_sync) |=> !bus_grant_n_o;
  endproperty
  a_reset_grant: assert property (p_reset_grant)
    else $error("No immediate grant during reset");

  property p_drivers_back;
    @(posedge clk_i) disable iff (rst_i)
      $rose(bus_grant_n_o) |-> drivers_en_o;
  endproperty
  a_drivers_back: assert property (p_drivers_back)
    else $error("Drivers not re-enabled at release");

  // Sequences for the grant hand-over and the hand-back
  sequence s_floating;
    ce_i && state_reg.st == ST_FLOAT && state_reg.req_sync;
  endsequence

  sequence s_handed_over;
    !bus_grant_n_o && !drivers_en_o;
  endsequence

  sequence s_release_seen;
    ce_i && state_reg.st == ST_GRANTED && !state_reg.req_sync;
  endsequence

  sequence s_handed_back;
    bus_grant_n_o && grant_hung_n_o && drivers_en_o && !core_stall_o;
  endsequence

  // Float step is followed by the grant, drivers still off
  property p_float_then_grant;
    @(posedge clk_i) disable iff (rst_i)
      s_floating |=> s_handed_over;
  endproperty
  a_float_then_grant: assert property (p_float_then_grant)
    else $error("Grant not given after drivers floated");

  // Hand-back restores grant, hung and drivers on one edge, and it sticks
  property p_hand_back;
    @(posedge clk_i) disable iff (rst_i)
      s_release_seen |=> s_handed_back ##1 bus_grant_n_o;
  endproperty
  a_hand_back: assert property (p_hand_back)
    else $error("Bus not handed back cleanly");

  // Hung grant raised one edge after a fetch waits on the granted bus
  property p_hung_follows;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && state_reg.st == ST_GRANTED && state_reg.req_sync && ext_fetch_i) |=> !grant_hung_n_o;
  endproperty
  a_hung_follows: assert property (p_hung_follows)
    else $error("Hung grant missing while core waits");

  // No grant on the edge after the device still owned the bus
  property p_no_early_grant;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg.st == ST_OWNED) |=> bus_grant_n_o;
  endproperty
  a_no_early_grant: assert property (p_no_early_grant)
    else $error("Grant straight from owned state");

  // Float only after a full wait count
  property p_float_after_count;
    @(posedge clk_i) disable iff (rst_i)
      $changed(state_reg.st) && state_reg.st == ST_FLOAT |->
        $past(state_reg.st) == ST_WAIT && wait_done($past(state_reg.cnt));
  endproperty
  a_float_after_count: assert property (p_float_after_count)
    else $error("Drivers floated before the wait count ended");

  // Internal traffic keeps the bus at home
  property p_busy_holds;
    @(posedge clk_i) disable iff (rst_i)
      (internal_busy && bus_grant_n_o && drivers_en_o) |=> bus_grant_n_o && drivers_en_o;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("Bus given away during internal traffic");

  // During reset with no request the device holds the bus, drivers on
  property p_reset_owned;
    @(posedge clk_i)
      (rst_i && ce_i && !state_reg.req_sync) |=> bus_grant_n_o && drivers_en_o;
  endproperty
  a_reset_owned: assert property (p_reset_owned)
    else $error("Bus not owned during idle reset");

  // Synchroniser: second stage copies the first, one edge later
  property p_sync_chain;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> state_reg.req_sync == $past(state_reg.req_meta);
  endproperty
  a_sync_chain: assert property (p_sync_chain)
    else $error("Request synchroniser stage skipped");

  // Clock enable low freezes every bit of state
  property p_freeze;
    @(posedge clk_i)
      !ce_i |=> $stable(state_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved with clock enable low");

  // Core runs on once the bus is home
  property p_no_stall_home;
    @(posedge clk_i)
      (bus_grant_n_o && drivers_en_o) |-> !core_stall_o;
  endproperty
  a_no_stall_home: assert property (p_no_stall_home)
    else $error("Core stalled with bus at home");

endmodule : external_bus_grant_arbiter
`default_nettype wire

/* tb/bus_master_model.sv */
/*
  Behavioural outside bus master: requests the bus, keeps it for a
  set number of granted cycles, then lets go.
  Assumes the arbiter's grant output and the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input wire logic clk_i, // Peripheral clock
  input wire logic go_i, // Start one tenure
  input wire logic [7:0] hold_i, // Granted cycles to keep the bus
  input wire logic bus_grant_n_i, // Grant from the device, low
  output logic ext_bus_request_n_o // Request to the device, low
);
  logic [7:0] cnt_reg; // Granted cycles so far

  initial begin
    ext_bus_request_n_o = 1'b1;
    cnt_reg = 8'h00;
  end

  // Request changes land just after the edge, like the bench stimulus
  always @(posedge clk_i) begin
    if (go_i) begin
      ext_bus_request_n_o <= #1 1'b0;
    end else if (!ext_bus_request_n_o && !bus_grant_n_i) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == hold_i) begin // Done with the bus: give it back
        ext_bus_request_n_o <= #1 1'b1;
        cnt_reg <= 8'h00;
      end
    end
  end
endmodule : bus_master_model

`default_nettype wire

/* tb/external_bus_grant_arbiter_tb.sv */
/*
  Self-checking bench for the external bus grant arbiter.
  Assumes the bus master model is compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module external_bus_grant_arbiter_tb;
  logic clk_i, rst_i, go, fetch, ce; // Clock, reset, tenure start, fetch, enable
  logic [5:0] blk; // Internal sources that hold the bus
  logic [7:0] hold; // Tenure length
  logic req_n, grant_n, hung_n, drv_en, stall; // Observed wires
  int num_errors, checked, n;

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  bus_master_model i_bus_master_model (.clk_i(clk_i), .go_i(go), .hold_i(hold),
    .bus_grant_n_i(grant_n), .ext_bus_request_n_o(req_n));

  // Boot flags share one blocker bit
  external_bus_grant_arbiter i_external_bus_grant_arbiter (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .ext_bus_request_n_i(req_n), .core_req_i(blk[0]), .periph_req_i(blk[1]),
    .access_busy_i(blk[2]), .read_pair_i(blk[3]), .exclusive_i(blk[4]),
    .boot_active_i(blk[5]), .boot_byte_busy_i(blk[5]), .ext_fetch_i(fetch),
    .bus_grant_n_o(grant_n), .grant_hung_n_o(hung_n), .drivers_en_o(drv_en),
    .core_stall_o(stall));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc

  // Bounded wait for the grant line, edges counted in n
  task automatic wait_grant(input logic lvl);
    n = 0;
    while (grant_n !== lvl && n < 40) begin
      cyc(1);
      n++;
    end
  endtask : wait_grant

  task automatic start(input logic [7:0] h);
    hold = h;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask : start

  // Plain grant and return, drivers floated before grant
  task automatic t_basic();
    logic drv_prev;
    drv_prev = 1'b1;
    start(8'h04);
    n = 0;
    while (grant_n !== 1'b0 && n < 40) begin
      drv_prev = drv_en;
      cyc(1);
      n++;
    end
    chk({7'h0, n >= 4 && n <= 9}, 8'h01);
    chk({7'h0, drv_prev}, 8'h00);
    wait_grant(1'b1);
    chk({6'h0, drv_en, hung_n}, 8'h03);
  endtask : t_basic

  // Clock enable low freezes the arbiter; the request waits it out
  task automatic t_freeze();
    ce = 1'b0;
    start(8'h02);
    cyc(12);
    chk({6'h0, grant_n, drv_en}, 8'h03);
    ce = 1'b1;
    wait_grant(1'b0);
    chk({7'h0, n >= 4 && n <= 9}, 8'h01);
    wait_grant(1'b1);
  endtask : t_freeze

  // Each internal source in turn keeps the request waiting
  task automatic t_block(input int i);
    blk = 6'h01 << i;
    start(8'h02);
    cyc(15);
    chk({7'h0, grant_n}, 8'h01);
    blk = 6'h00;
    wait_grant(1'b0);
    chk({7'h0, n <= 9}, 8'h01);
    wait_grant(1'b1);
  endtask : t_block

  // Core wants the bus while it is away: stall, hung, resume
  task automatic t_hung();
    start(8'h0a);
    wait_grant(1'b0);
    fetch = 1'b1;
    cyc(1);
    chk({7'h0, stall}, 8'h01);
    cyc(1);
    chk({7'h0, hung_n}, 8'h00);
    wait_grant(1'b1);
    chk({6'h0, hung_n, stall}, 8'h02);
    fetch = 1'b0;
  endtask : t_hung

  // Second reset in mid-run: grant still given, and quickly
  task automatic t_reset();
    rst_i = 1'b1;
    start(8'h03);
    wait_grant(1'b0);
    chk({7'h0, n <= 6}, 8'h01);
    chk({7'h0, drv_en}, 8'h00);
    wait_grant(1'b1);
    rst_i = 1'b0;
    cyc(2);
  endtask : t_reset

  task automatic conclude();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rst_i = 1'b1;
    go = 1'b0;
    fetch = 1'b0;
    ce = 1'b1;
    blk = 6'h00;
    hold = 8'h00;
    num_errors = 0;
    checked = 0;
    cyc(10);
    rst_i = 1'b0;
    t_basic();
    t_freeze();
    for (int i = 0; i < 6; i++) begin
      t_block(i);
    end
    t_hung();
    t_reset();
    conclude();
  end

  // Watchdog, about nine times the expected run
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
endmodule : external_bus_grant_arbiter_tb

`default_nettype wire
